// file: src/dcc_top.sv
// Serial-bus register bank for diode compensation, smoothing and limit flags.
//
// Function
// - Register 25h is read-write, resets to 08h, auto in bit 3, factor in 2:0.
// - With auto-detect at 0 the automatic factor detection is turned off.
// - With auto-detect at 1 a detected factor is applied at each conversion.
// - A read-write register at 27h holds a 6-bit diode factor, reset 12h.
// - Diode-model codes 08h to 37h mean rising factors, 12h being 1.0080.
// - Transistor-model codes map lower, 12h being unity and 37h being 1.0486.
// - External and internal high-limit flags sit in bits 1 and 0.
// - External and internal low-limit flags sit in bits 1 and 0.
// - Critical flags sit in bits 1 and 0 and either one asserts the pin.
// - A read-write register at 40h resets to 00h, bits 1:0 select smoothing.
// - Smoothing 00 is off, 01 and 10 are level one, 11 is level two.
// - The critical pin is released only below the limit minus hysteresis.
`timescale 1ns/1ns
`default_nettype none
module dcc_top
  import dcc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic smclk_in,
  input wire logic smdata_in,
  output logic smdata_out,
  output logic smdata_oe,
  output logic therm_n,
  input wire logic link_clk,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [2:0] detected_comp,
  input wire logic ext_over_high,
  input wire logic int_over_high,
  input wire logic ext_under_low,
  input wire logic int_under_low,
  input wire logic ext_over_crit,
  input wire logic int_over_crit,
  input wire logic ext_under_crit_hyst,
  input wire logic int_under_crit_hyst,
  output logic auto_detect_en,
  output logic [2:0] comp_factor,
  output logic [5:0] diode_factor,
  output logic [1:0] smoothing_level
);

  // Pin sampling and bus condition detection.
  logic [1:0] pin_q;
  logic scl;
  logic sda;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  dcc_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({smclk_in, smdata_in}),
    .q(pin_q)
  );

  assign scl = pin_q[1];
  assign sda = pin_q[0];
  assign scl_rise = scl & ~scl_prev_reg;
  assign scl_fall = ~scl & scl_prev_reg;
  assign bus_start = scl & scl_prev_reg & sda_prev_reg & ~sda;
  assign bus_stop = scl & scl_prev_reg & ~sda_prev_reg & sda;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
    end
  end

  // Register bank and flags.
  logic [3:0] comp_cfg_reg, comp_cfg_next;
  logic [5:0] diode_factor_reg, diode_factor_next;
  logic [1:0] smooth_reg, smooth_next;
  logic [1:0] high_flag_reg, high_flag_next;
  logic [1:0] low_flag_reg, low_flag_next;
  logic [1:0] crit_flag_q;
  logic therm_n_reg, therm_n_next;
  logic [7:0] ptr_reg, ptr_next;
  logic wr_en;
  logic rd_load;
  logic [7:0] rd_data;
  logic [3:0] ev_set;

  // Bus engine state.
  dcc_bus_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic rw_reg, rw_next;
  logic oe_reg, oe_next;

  always_comb begin
    rd_data = 8'h00;
    if (ptr_reg == COMP_CFG_ADDR) begin
      rd_data = {4'h0, comp_cfg_reg};
    end else if (ptr_reg == DIODE_FACTOR_ADDR) begin
      rd_data = {2'h0, diode_factor_reg};
    end else if (ptr_reg == SMOOTH_CTRL_ADDR) begin
      rd_data = {6'h00, smooth_reg};
    end else if (ptr_reg == HIGH_STAT_ADDR) begin
      rd_data = {6'h00, high_flag_reg};
    end else if (ptr_reg == LOW_STAT_ADDR) begin
      rd_data = {6'h00, low_flag_reg};
    end else if (ptr_reg == CRIT_STAT_ADDR) begin
      rd_data = {6'h00, crit_flag_q};
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    ptr_next = ptr_reg;
    wr_en = 1'b0;
    rd_load = 1'b0;
    if (bus_start) begin
      state_next = ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
            oe_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == SLAVE_ADDR) begin
                rw_next = shift_reg[0];
                state_next = ST_ADDR_ACK;
              end else begin
                oe_next = 1'b0;
                state_next = ST_IDLE;
              end
            end else if (state_reg == ST_CMD) begin
              ptr_next = shift_reg;
              state_next = ST_CMD_ACK;
            end else begin
              wr_en = 1'b1;
              state_next = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK, ST_RDATA_ACK: begin
          if (scl_rise && state_reg == ST_RDATA_ACK && sda) begin
            state_next = ST_IDLE;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            oe_next = 1'b0;
            if ((state_reg == ST_ADDR_ACK && rw_reg) ||
                state_reg == ST_RDATA_ACK) begin
              rd_load = 1'b1;
              shift_next = rd_data;
              oe_next = ~rd_data[7];
              state_next = ST_RDATA;
            end else if (state_reg == ST_ADDR_ACK) begin
              state_next = ST_CMD;
            end else begin
              state_next = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_reg == LAST_TX_BIT) begin
              oe_next = 1'b0;
              state_next = ST_RDATA_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      ptr_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      ptr_reg <= ptr_next;
    end
  end

  // Writes land on the byte just received; reserved bits are dropped.
  always_comb begin
    comp_cfg_next = comp_cfg_reg;
    diode_factor_next = diode_factor_reg;
    smooth_next = smooth_reg;
    if (wr_en) begin
      if (ptr_reg == COMP_CFG_ADDR) begin
        comp_cfg_next = shift_reg[3:0];
      end else if (ptr_reg == DIODE_FACTOR_ADDR) begin
        diode_factor_next = shift_reg[5:0];
      end else if (ptr_reg == SMOOTH_CTRL_ADDR) begin
        smooth_next = shift_reg[1:0];
      end
    end
  end

  // Reading the high or low status byte clears it, but a flag set in the same cycle stays.
  always_comb begin
    high_flag_next = high_flag_reg;
    low_flag_next = low_flag_reg;
    if (rd_load && ptr_reg == HIGH_STAT_ADDR) begin
      high_flag_next = 2'h0;
    end
    if (rd_load && ptr_reg == LOW_STAT_ADDR) begin
      low_flag_next = 2'h0;
    end
    high_flag_next = high_flag_next | ev_set[3:2];
    low_flag_next = low_flag_next | ev_set[1:0];
    therm_n_next = ~(crit_flag_q[EXT_BIT] | crit_flag_q[INT_BIT]);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comp_cfg_reg <= COMP_CFG_RST;
      diode_factor_reg <= DIODE_FACTOR_RST;
      smooth_reg <= SMOOTH_RST;
      high_flag_reg <= 2'h0;
      low_flag_reg <= 2'h0;
      therm_n_reg <= 1'b1;
    end else begin
      comp_cfg_reg <= comp_cfg_next;
      diode_factor_reg <= diode_factor_next;
      smooth_reg <= smooth_next;
      high_flag_reg <= high_flag_next;
      low_flag_reg <= low_flag_next;
      therm_n_reg <= therm_n_next;
    end
  end

  // Configuration word crosses by toggle handshake; held still until acked.
  logic [CFG_W-1:0] cfg_live;
  logic [CFG_W-1:0] cfg_hold_reg, cfg_hold_next;
  logic cfg_req_reg, cfg_req_next;
  logic cfg_ack_q;
  logic ev_req_q;
  logic ev_ack_reg, ev_ack_next;
  logic [3:0] ev_hold_reg, ev_hold_next;
  logic [1:0] link_crit_reg, link_crit_next;
  logic cfg_ack_reg_l, cfg_ack_next_l;
  logic ev_req_reg_l, ev_req_next_l;

  assign cfg_live = {comp_cfg_reg, diode_factor_reg, smooth_reg};

  dcc_sync #(.W(2)) u_sys_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({cfg_ack_reg_l, ev_req_reg_l}),
    .q({cfg_ack_q, ev_req_q})
  );

  dcc_sync #(.W(2)) u_crit_sync (
    .clk(clk),
    .rst(sys_rst),
    .d(link_crit_reg),
    .q(crit_flag_q)
  );

  always_comb begin
    cfg_hold_next = cfg_hold_reg;
    cfg_req_next = cfg_req_reg;
    ev_ack_next = ev_ack_reg;
    ev_set = 4'h0;
    if (cfg_ack_q == cfg_req_reg && cfg_live != cfg_hold_reg) begin
      cfg_hold_next = cfg_live;
      cfg_req_next = ~cfg_req_reg;
    end
    if (ev_req_q != ev_ack_reg) begin
      ev_set = ev_hold_reg;
      ev_ack_next = ~ev_ack_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_hold_reg <= {COMP_CFG_RST, DIODE_FACTOR_RST, SMOOTH_RST};
      cfg_req_reg <= 1'b0;
      ev_ack_reg <= 1'b0;
    end else begin
      cfg_hold_reg <= cfg_hold_next;
      cfg_req_reg <= cfg_req_next;
      ev_ack_reg <= ev_ack_next;
    end
  end

  // Link domain: measurement side, clocked by the converter's own clock.
  logic link_rst;
  logic [1:0] link_q;
  logic [CFG_W-1:0] app_cfg_reg, app_cfg_next;
  logic [2:0] app_comp_reg, app_comp_next;
  logic [1:0] level_reg, level_next;
  logic [3:0] ev_pend_reg, ev_pend_next;
  logic [3:0] ev_new;
  logic [3:0] app_comp_cfg;

  dcc_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d(sys_rst),
    .q(link_rst)
  );

  dcc_sync #(.W(2)) u_link_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d({cfg_req_reg, ev_ack_reg}),
    .q(link_q)
  );

  assign app_comp_cfg = app_cfg_reg[CFG_W-1 -: COMP_CFG_W];
  assign ev_new = conv_done ?
    {ext_over_high, int_over_high, ext_under_low, int_under_low} : 4'h0;

  always_comb begin
    app_cfg_next = app_cfg_reg;
    cfg_ack_next_l = cfg_ack_reg_l;
    app_comp_next = app_comp_reg;
    link_crit_next = link_crit_reg;
    ev_pend_next = ev_pend_reg | ev_new;
    ev_hold_next = ev_hold_reg;
    ev_req_next_l = ev_req_reg_l;
    if (link_q[1] != cfg_ack_reg_l) begin
      app_cfg_next = cfg_hold_reg;
      cfg_ack_next_l = ~cfg_ack_reg_l;
    end
    // The factor is fixed once per conversion, at its start.
    if (conv_start) begin
      if (app_comp_cfg[COMP_AUTO_BIT]) begin
        app_comp_next = detected_comp;
      end else begin
        app_comp_next = app_comp_cfg[COMP_FACTOR_W-1:0];
      end
    end
    // A flag holds until the result is below limit minus hysteresis.
    if (conv_done) begin
      if (ext_over_crit) begin
        link_crit_next[EXT_BIT] = 1'b1;
      end else if (ext_under_crit_hyst) begin
        link_crit_next[EXT_BIT] = 1'b0;
      end
      if (int_over_crit) begin
        link_crit_next[INT_BIT] = 1'b1;
      end else if (int_under_crit_hyst) begin
        link_crit_next[INT_BIT] = 1'b0;
      end
    end
    // Events batch up while a handshake is out, so none is lost.
    if (link_q[0] == ev_req_reg_l && ev_pend_next != 4'h0) begin
      ev_hold_next = ev_pend_next;
      ev_req_next_l = ~ev_req_reg_l;
      ev_pend_next = 4'h0;
    end
    case (app_cfg_next[SMOOTH_W-1:0])
      SMOOTH_OFF: level_next = SMOOTH_OFF;
      SMOOTH_SEL_L2: level_next = SMOOTH_L2;
      default: level_next = SMOOTH_L1;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      app_cfg_reg <= {COMP_CFG_RST, DIODE_FACTOR_RST, SMOOTH_RST};
      cfg_ack_reg_l <= 1'b0;
      app_comp_reg <= COMP_CFG_RST[2:0];
      link_crit_reg <= 2'h0;
      ev_pend_reg <= 4'h0;
      ev_hold_reg <= 4'h0;
      ev_req_reg_l <= 1'b0;
      level_reg <= SMOOTH_OFF;
    end else begin
      app_cfg_reg <= app_cfg_next;
      cfg_ack_reg_l <= cfg_ack_next_l;
      app_comp_reg <= app_comp_next;
      link_crit_reg <= link_crit_next;
      ev_pend_reg <= ev_pend_next;
      ev_hold_reg <= ev_hold_next;
      ev_req_reg_l <= ev_req_next_l;
      level_reg <= level_next;
    end
  end

  // Open-drain data: the pin is only ever pulled low.
  logic out_zero_reg;
  always_ff @(posedge clk) begin
    out_zero_reg <= 1'b0;
  end

  assign smdata_out = out_zero_reg;
  assign smdata_oe = oe_reg;
  assign therm_n = therm_n_reg;
  assign auto_detect_en = app_comp_cfg[COMP_AUTO_BIT];
  assign comp_factor = app_comp_reg;
  // The code goes out unchanged; the model tables live in the front end.
  assign diode_factor = app_cfg_reg[SMOOTH_W +: DIODE_FACTOR_W];
  assign smoothing_level = level_reg;

endmodule // dcc_top
`default_nettype wire

// file: src/dcc_pkg.sv
// Constants and types shared by the diode compensation configuration block.
package dcc_pkg;

  localparam logic [7:0] COMP_CFG_ADDR = 8'h25;
  localparam logic [7:0] DIODE_FACTOR_ADDR = 8'h27;
  localparam logic [7:0] SMOOTH_CTRL_ADDR = 8'h40;
  localparam logic [7:0] HIGH_STAT_ADDR = 8'h30;
  localparam logic [7:0] LOW_STAT_ADDR = 8'h31;
  localparam logic [7:0] CRIT_STAT_ADDR = 8'h32;

  localparam int COMP_CFG_W = 4;
  localparam int COMP_AUTO_BIT = 3;
  localparam int COMP_FACTOR_W = 3;
  localparam int DIODE_FACTOR_W = 6;
  localparam int SMOOTH_W = 2;
  localparam int EXT_BIT = 1;
  localparam int INT_BIT = 0;

  localparam logic [3:0] COMP_CFG_RST = 4'h8;
  localparam logic [5:0] DIODE_FACTOR_RST = 6'h12;
  localparam logic [1:0] SMOOTH_RST = 2'h0;

  localparam logic [1:0] SMOOTH_OFF = 2'h0;
  localparam logic [1:0] SMOOTH_L1 = 2'h1;
  localparam logic [1:0] SMOOTH_L2 = 2'h2;
  localparam logic [1:0] SMOOTH_SEL_L2 = 2'h3;

  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // Packed order of the configuration word that crosses into the link domain.
  localparam int CFG_W = COMP_CFG_W + DIODE_FACTOR_W + SMOOTH_W;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } dcc_bus_state_e;

endpackage

// file: src/dcc_sync.sv
// Three-stage synchroniser that passes a bit once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module dcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      logic q_next;
      // Only the second stage looks at the first one.
      always_comb begin
        q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_reg <= RST_VAL[i];
          s2_reg <= RST_VAL[i];
          s3_reg <= RST_VAL[i];
          q_reg <= RST_VAL[i];
        end else begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          q_reg <= q_next;
        end
      end
      assign q[i] = q_reg;
    end
  endgenerate
endmodule // dcc_sync
`default_nettype wire

// file: verif/dcc_monitor.sv
// Concurrent checks on the ports of the diode compensation register block.
`timescale 1ns/1ns
`default_nettype none
module dcc_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic smclk_in,
  input wire logic smdata_oe,
  input wire logic therm_n,
  input wire logic link_clk,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [2:0] detected_comp,
  input wire logic ext_over_crit,
  input wire logic int_over_crit,
  input wire logic ext_under_crit_hyst,
  input wire logic int_under_crit_hyst,
  input wire logic auto_detect_en,
  input wire logic [2:0] comp_factor,
  input wire logic [5:0] diode_factor,
  input wire logic [1:0] smoothing_level
);
  rst_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> !smdata_oe && therm_n)
    else $error("bus or critical pin active out of reset");
  link_reset_a: assert property (@(posedge link_clk)
    disable iff (sys_rst) $fell(sys_rst) |-> auto_detect_en &&
    comp_factor == 3'h0 && diode_factor == 6'h12 && smoothing_level == 2'h0)
    else $error("link outputs not at reset values");
  auto_factor_a: assert property (@(posedge link_clk)
    disable iff (sys_rst) conv_start && auto_detect_en
    |=> comp_factor == $past(detected_comp))
    else $error("detected factor lost");
  factor_hold_a: assert property (@(posedge link_clk)
    disable iff (sys_rst) !conv_start |=> $stable(comp_factor))
    else $error("factor changed outside a conversion start");
  smooth_code_a: assert property (@(posedge link_clk)
    disable iff (sys_rst) smoothing_level != 2'h3)
    else $error("smoothing level out of range");
  crit_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(conv_done) && (ext_over_crit || int_over_crit) |-> ##[1:80] !therm_n)
    else $error("critical pin not asserted");
  crit_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(conv_done) && ext_under_crit_hyst && int_under_crit_hyst &&
    !ext_over_crit && !int_over_crit |-> ##[1:80] therm_n)
    else $error("critical pin not released");
  ack_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(smdata_oe) |-> !smclk_in)
    else $error("data driven while bus clock high");
  cover property (@(posedge clk) $rose(conv_done) && int_over_crit);
  cover property (@(posedge link_clk) conv_start && !auto_detect_en);
  cover property (@(posedge clk) $rose(smdata_oe));
endmodule // dcc_monitor
bind dcc_top dcc_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .smclk_in(smclk_in), .smdata_oe(smdata_oe), .therm_n(therm_n),
  .link_clk(link_clk), .conv_start(conv_start), .conv_done(conv_done),
  .detected_comp(detected_comp), .ext_over_crit(ext_over_crit),
  .int_over_crit(int_over_crit), .ext_under_crit_hyst(ext_under_crit_hyst),
  .int_under_crit_hyst(int_under_crit_hyst),
  .auto_detect_en(auto_detect_en), .comp_factor(comp_factor),
  .diode_factor(diode_factor), .smoothing_level(smoothing_level));
`default_nettype wire

// file: verif/dcc_host_model.sv
// Serial bus host model driving the clock and an open-drain data line.
`timescale 1ns/1ns
`default_nettype none
module dcc_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves 5 clk after the clock falls so the pin filter never sees it
  // change while the clock still reads high.
  task automatic xfer(input logic b, output logic r);
    tick(5);
    sda_drv <= b;
    tick(15);
    scl <= 1'b1;
    tick(20);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start;
    tick(5);
    sda_drv <= 1'b1;
    tick(15);
    scl <= 1'b1;
    tick(20);
    sda_drv <= 1'b0;
    tick(20);
    scl <= 1'b0;
  endtask
  task automatic stop;
    tick(5);
    sda_drv <= 1'b0;
    tick(15);
    scl <= 1'b1;
    tick(20);
    sda_drv <= 1'b1;
    tick(20);
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(v[i], r);
    xfer(1'b1, r);
    ack = !r;
  endtask
  task automatic write_reg(input logic [6:0] sa, input logic [7:0] a,
                           input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start;
    send({sa, 1'b0}, k1);
    send(a, k2);
    send(d, k3);
    stop;
    ok = k1 & k2 & k3;
  endtask
  task automatic read_reg(input logic [6:0] sa, input logic [7:0] a,
                          output logic [7:0] d, output logic ok);
    logic k1, k2, k3, r;
    start;
    send({sa, 1'b0}, k1);
    send(a, k2);
    start;
    send({sa, 1'b1}, k3);
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(1'b1, r);
    stop;
    ok = k1 & k2 & k3;
  endtask
endmodule // dcc_host_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the diode compensation register block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  import dcc_pkg::*;
  localparam logic [6:0] SLAVE = DEFAULT_SLAVE_ADDR;
  logic clk, sys_rst, link_clk, conv_start, conv_done;
  logic scl, sda_drv, sda_oe, sda_out, therm_n, auto_en;
  logic [2:0] det, comp;
  logic [7:0] cmp;
  logic [5:0] dfac;
  logic [1:0] smooth;
  wire logic sda;
  int n_mismatch = 0;
  int tests_run = 0;
  // The device side only ever sinks; a high drive value would break acks.
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  dcc_top #(.SLAVE_ADDR(SLAVE)) DUT (.clk(clk), .sys_rst(sys_rst),
    .smclk_in(scl), .smdata_in(sda), .smdata_out(sda_out),
    .smdata_oe(sda_oe), .therm_n(therm_n), .link_clk(link_clk),
    .conv_start(conv_start), .conv_done(conv_done), .detected_comp(det),
    .ext_over_high(cmp[7]), .int_over_high(cmp[6]),
    .ext_under_low(cmp[5]), .int_under_low(cmp[4]),
    .ext_over_crit(cmp[3]), .int_over_crit(cmp[2]),
    .ext_under_crit_hyst(cmp[1]), .int_under_crit_hyst(cmp[0]),
    .auto_detect_en(auto_en), .comp_factor(comp),
    .diode_factor(dfac), .smoothing_level(smooth));
  dcc_host_model HOST (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #4;
    forever #32 link_clk = ~link_clk;
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    HOST.write_reg(SLAVE, a, d, ok);
    `CHK("write ack", 1'b1, ok)
    repeat (20) @(posedge link_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    HOST.read_reg(SLAVE, a, d, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK("read data", e, d)
  endtask
  // One conversion; the detected code moves away right after its sample.
  task automatic conv(input logic [2:0] d, input logic [7:0] c);
    @(posedge link_clk);
    conv_start <= 1'b1;
    det <= d;
    @(posedge link_clk);
    conv_start <= 1'b0;
    conv_done <= 1'b1;
    cmp <= c;
    @(posedge link_clk);
    conv_done <= 1'b0;
    cmp <= 8'h00;
    det <= ~d;
    repeat (20) @(posedge link_clk);
  endtask
  task automatic t_reset;
    `CHK("auto_detect_en", 1'b1, auto_en)
    `CHK("diode_factor", 6'h12, dfac)
    `CHK("smoothing_level", 2'h0, smooth)
    rd(COMP_CFG_ADDR, 8'h08);
    rd(DIODE_FACTOR_ADDR, 8'h12);
    rd(SMOOTH_CTRL_ADDR, 8'h00);
  endtask
  task automatic t_regs;
    logic [1:0] lv;
    for (int i = 0; i < 4; i++) begin
      wr(SMOOTH_CTRL_ADDR, 8'(i));
      lv = (i == 3) ? 2'h2 : (i == 0) ? 2'h0 : 2'h1;
      `CHK("smoothing_level", lv, smooth)
    end
    wr(SMOOTH_CTRL_ADDR, 8'hfc);
    rd(SMOOTH_CTRL_ADDR, 8'h00);
    `CHK("smoothing_level", 2'h0, smooth)
    wr(DIODE_FACTOR_ADDR, 8'hf7);
    rd(DIODE_FACTOR_ADDR, 8'h37);
    `CHK("diode_factor", 6'h37, dfac)
    wr(DIODE_FACTOR_ADDR, 8'h15);
    rd(DIODE_FACTOR_ADDR, 8'h15);
    `CHK("diode_factor", 6'h15, dfac)
    wr(8'h50, 8'ha5);
    rd(8'h50, 8'h00);
    wr(COMP_CFG_ADDR, 8'hf5);
    rd(COMP_CFG_ADDR, 8'h05);
    `CHK("auto_detect_en", 1'b0, auto_en)
  endtask
  task automatic t_comp;
    conv(3'h2, 8'h00);
    `CHK("comp_factor", 3'h5, comp)
    wr(COMP_CFG_ADDR, 8'h0e);
    `CHK("auto_detect_en", 1'b1, auto_en)
    conv(3'h3, 8'h00);
    `CHK("comp_factor", 3'h3, comp)
    conv(3'h1, 8'h00);
    `CHK("comp_factor", 3'h1, comp)
  endtask
  task automatic t_flags;
    conv(3'h0, 8'h90);
    conv(3'h0, 8'h60);
    rd(HIGH_STAT_ADDR, 8'h03);
    rd(LOW_STAT_ADDR, 8'h03);
    rd(HIGH_STAT_ADDR, 8'h00);
    conv(3'h0, 8'h04);
    `CHK("therm_n", 1'b0, therm_n)
    rd(CRIT_STAT_ADDR, 8'h01);
    conv(3'h0, 8'h08);
    conv(3'h0, 8'h00);
    `CHK("therm_n", 1'b0, therm_n)
    rd(CRIT_STAT_ADDR, 8'h03);
    conv(3'h0, 8'h01);
    rd(CRIT_STAT_ADDR, 8'h02);
    `CHK("therm_n", 1'b0, therm_n)
    conv(3'h0, 8'h03);
    `CHK("therm_n", 1'b1, therm_n)
    rd(CRIT_STAT_ADDR, 8'h00);
  endtask
  task automatic t_addr;
    logic ok;
    HOST.write_reg(SLAVE ^ 7'h01, COMP_CFG_ADDR, 8'h00, ok);
    `CHK("foreign address ack", 1'b0, ok)
    rd(COMP_CFG_ADDR, 8'h0e);
  endtask
  // The reset is held well past two cycles so the link side sees it too.
  initial begin
    sys_rst = 1'b1;
    conv_start = 1'b0;
    conv_done = 1'b0;
    det = 3'h0;
    cmp = 8'h00;
    repeat (40) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset;
    t_regs;
    t_comp;
    t_flags;
    t_addr;
    test_done;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
